// [core/prh_defines.svh]
// constants of the reconfiguration handshake: timing, offsets, fields
`ifndef PRH_DEFINES_SVH
`define PRH_DEFINES_SVH
`define PRH_DATA_W         32
`define PRH_CORE_PERIOD_NS 40
`define PRH_LINK_PERIOD_NS 320
`define PRH_CLK_DIV        (`PRH_LINK_PERIOD_NS / `PRH_CORE_PERIOD_NS)
`define PRH_REQ_GAP_CYC    10
`define PRH_READY_DLY      4
`define PRH_REG_CTRL       4'h0
`define PRH_REG_LEN        4'h4
`define PRH_REG_DATA       4'h8
`define PRH_REG_STAT       4'hC
`define PRH_CTRL_START     0
`define PRH_CTRL_ABORT     1
`define PRH_CTRL_WIDTH_LSB 4
`define PRH_STAT_BUSY      0
`define PRH_STAT_READY     1
`define PRH_STAT_DONE      2
`define PRH_STAT_ERROR     3
`define PRH_STAT_UNDERRUN  4
`define PRH_STAT_STATE_LSB 8
`define PRH_LEN_RESET      32'h0000_0000
`endif

// [core/prh_pkg.sv]
// types shared by both ends of the reconfiguration handshake
`include "prh_defines.svh"
package prh_pkg;
  typedef enum logic [1:0] {
    PRH_W8  = 2'h0,
    PRH_W16 = 2'h1,
    PRH_W32 = 2'h2
  } prh_width_t;

  typedef enum logic [2:0] {
    PRH_H_IDLE    = 3'h0,
    PRH_H_REQ     = 3'h1,
    PRH_H_STREAM  = 3'h3,
    PRH_H_FLUSH   = 3'h2,
    PRH_H_RELEASE = 3'h6,
    PRH_H_GAP     = 3'h7,
    PRH_H_ERRWAIT = 3'h5
  } prh_host_state_t;

  typedef enum logic [2:0] {
    PRH_D_IDLE = 3'h0,
    PRH_D_ARM  = 3'h1,
    PRH_D_RECV = 3'h3,
    PRH_D_DONE = 3'h2,
    PRH_D_ERR  = 3'h6,
    PRH_D_CHK  = 3'h4
  } prh_dev_state_t;

  function automatic logic [`PRH_DATA_W-1:0] prh_mask(
    input prh_width_t             w,
    input logic [`PRH_DATA_W-1:0] d
  );
    logic [`PRH_DATA_W-1:0] m;
    m = 32'hFFFF_FFFF;
    if (w == PRH_W8) begin
      m = 32'h0000_00FF;
    end else if (w == PRH_W16) begin
      m = 32'h0000_FFFF;
    end
    return d & m;
  endfunction : prh_mask
endpackage : prh_pkg

// [core/prh_if.sv]
// link between reconfiguration host and control block
`include "prh_defines.svh"
interface prh_if;
  logic                   reconfig_request;
  logic                   reconfig_ready;
  logic                   reconfig_done;
  logic                   reconfig_error;
  logic                   checksum_error;
  logic                   source_select;
  logic                   bitstream_clock;
  logic [`PRH_DATA_W-1:0] bitstream_data;

  modport device (
    input  reconfig_request,
    input  source_select,
    input  bitstream_clock,
    input  bitstream_data,
    output reconfig_ready,
    output reconfig_done,
    output reconfig_error,
    output checksum_error
  );

  modport host (
    output reconfig_request,
    output source_select,
    output bitstream_clock,
    output bitstream_data,
    input  reconfig_ready,
    input  reconfig_done,
    input  reconfig_error,
    input  checksum_error
  );
endinterface : prh_if

// [core/prh_device.sv]
// control block end: handshake, bitstream intake, frame-check error
`include "prh_defines.svh"
module prh_device
  import prh_pkg::*;
#(
  parameter int READY_DLY = `PRH_READY_DLY
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   arst_n_i,
  prh_if.device                       link,
  input  wire logic                   pin_mode_i,
  input  wire prh_width_t             width_i,
  input  wire logic [`PRH_DATA_W-1:0] length_i,
  input  wire logic                   xfer_fault_i,
  input  wire logic                   frame_mismatch_i,
  output logic      [`PRH_DATA_W-1:0] word_o,
  output logic                        word_valid_o
);
  typedef struct packed {
    prh_dev_state_t         st;
    logic [1:0]             req_s;
    logic [1:0]             sel_s;
    logic [2:0]             clk_s;
    logic [`PRH_DATA_W-1:0] d1;
    logic [`PRH_DATA_W-1:0] d2;
    logic [7:0]             dly;
    logic [`PRH_DATA_W-1:0] cnt;
    logic                   started;
    logic                   ready;
    logic                   done;
    logic                   error;
    logic                   crc;
    logic [`PRH_DATA_W-1:0] word;
    logic                   wv;
  } prh_dev_reg_t;

  prh_dev_reg_t s_r;
  prh_dev_reg_t s_nxt;
  logic         edge_w;
  logic         req_w;
  logic         take_w;

  always_comb begin
    s_nxt       = s_r;
    // request, select and data cross through two flops; the clock goes through three, the third only for the edge
    s_nxt.req_s = {s_r.req_s[0], link.reconfig_request};
    s_nxt.sel_s = {s_r.sel_s[0], link.source_select};
    s_nxt.clk_s = {s_r.clk_s[1:0], link.bitstream_clock};
    s_nxt.d1    = link.bitstream_data;
    s_nxt.d2    = s_r.d1;
    s_nxt.wv    = 1'b0;
    req_w       = s_r.req_s[1];
    edge_w      = s_r.clk_s[1] & ~s_r.clk_s[2];
    // the first nonzero word opens the stream; zero is idle fill
    take_w      = edge_w & (s_r.started | (s_r.d2 != 32'h0000_0000));
    unique case (s_r.st)
      PRH_D_IDLE: begin
        if (req_w && (s_r.sel_s[1] != pin_mode_i)) begin
          s_nxt.st  = PRH_D_ARM;
          s_nxt.dly = 8'h00;
        end
      end
      PRH_D_ARM: begin
        if (!req_w) begin
          s_nxt.st = PRH_D_IDLE;
        end else if (s_r.dly == 8'(READY_DLY - 1)) begin
          s_nxt.ready   = 1'b1;
          s_nxt.cnt     = 32'h0000_0000;
          s_nxt.started = 1'b0;
          s_nxt.st      = PRH_D_RECV;
        end else begin
          s_nxt.dly = s_r.dly + 8'h01;
        end
      end
      PRH_D_RECV: begin
        if (frame_mismatch_i) begin
          s_nxt.crc = 1'b1;
          s_nxt.st  = PRH_D_CHK;
        end else if (xfer_fault_i ||
                     (take_w && prh_mask(width_i, s_r.d2) != s_r.d2)) begin
          // bits above the chosen width count as a transmission error
          s_nxt.error = 1'b1;
          s_nxt.st    = PRH_D_ERR;
        end else if (!req_w) begin
          s_nxt.ready = 1'b0;
          s_nxt.st    = PRH_D_IDLE;
        end else if (take_w) begin
          s_nxt.started = 1'b1;
          s_nxt.word    = s_r.d2;
          s_nxt.wv      = 1'b1;
          s_nxt.cnt     = s_r.cnt + 32'h0000_0001;
          if (s_r.cnt + 32'h0000_0001 >= length_i) begin
            s_nxt.done  = 1'b1;
            s_nxt.ready = 1'b0;
            s_nxt.st    = PRH_D_DONE;
          end
        end
      end
      PRH_D_DONE: begin
        if (!req_w) begin
          s_nxt.done = 1'b0;
          s_nxt.st   = PRH_D_IDLE;
        end
      end
      PRH_D_CHK: begin
        s_nxt.error = 1'b1;
        s_nxt.st    = PRH_D_ERR;
      end
      PRH_D_ERR: begin
        // ready falls one cycle after error so error is seen first
        s_nxt.ready = 1'b0;
        if (!req_w && !s_r.ready) begin
          s_nxt.error = 1'b0;
          s_nxt.crc   = 1'b0;
          s_nxt.st    = PRH_D_IDLE;
        end
      end
      default: begin
        s_nxt.st = PRH_D_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.reconfig_ready = s_r.ready;
  assign link.reconfig_done  = s_r.done;
  assign link.reconfig_error = s_r.error;
  assign link.checksum_error = s_r.crc;
  assign word_o              = s_r.word;
  assign word_valid_o        = s_r.wv;
endmodule : prh_device

// [core/prh_host.sv]
// reconfiguration host end: register slave, clock divider, session control
// Function
// - data bus is 32 lines, width 8/16/32
// - only data follows bitstream clock
// - host drives free-running bitstream clock
// - data zero while awaiting ready
// - host raises and holds request
// - device raises ready when it can accept
// - one word every bitstream clock cycle
// - data back to zero after last word
// - device raises done, lowers ready
// - request drops after done, then done drops
// - on error, error rises then ready falls
// - device lowers error for next session
// - checksum error first, then error, ready low
// - device clears checksum error afterwards
// - request may drop after ready, before data
// - no re-request until ready seen; abort in PRH_H_REQ drops request before ready, next request after the gap
// - ten bitstream clocks between requests
// - source select high from core logic
`include "prh_defines.svh"
module prh_host
  import prh_pkg::*;
#(
  parameter int   DIV       = `PRH_CLK_DIV,
  parameter int   GAP       = `PRH_REQ_GAP_CYC,
  parameter logic FROM_CORE = 1'b1
) (
  input  wire logic                   core_clk_i,
  input  wire logic                   arst_n_i,
  prh_if.host                         link,
  input  wire logic [3:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [`PRH_DATA_W-1:0] avs_writedata_i,
  output logic      [`PRH_DATA_W-1:0] avs_readdata_o,
  output logic                        avs_waitrequest_o
);
  localparam int HALF = DIV / 2;

  typedef struct packed {
    prh_host_state_t        st;
    logic [7:0]             div;
    logic                   lclk;
    logic [1:0]             rdy_s;
    logic [1:0]             dn_s;
    logic [1:0]             er_s;
    logic [`PRH_DATA_W-1:0] data;
    logic                   req;
    logic [`PRH_DATA_W-1:0] cnt;
    logic [`PRH_DATA_W-1:0] len;
    prh_width_t             width;
    logic [3:0]             gap;
    logic                   rd_pend;
    logic [`PRH_DATA_W-1:0] rdata;
    logic                   done_seen;
    logic                   err_seen;
    logic                   underrun;
  } prh_host_reg_t;

  prh_host_reg_t s_r;
  prh_host_reg_t s_nxt;
  logic          rise_w;
  logic          fall_w;
  logic          rdy_w;
  logic          dn_w;
  logic          er_w;
  logic          wr_ctrl_w;
  logic          wr_data_w;
  logic          accept_w;
  logic          start_w;
  logic          abort_w;

  always_comb begin
    rise_w    = (s_r.div == 8'(DIV - 1));
    fall_w    = (s_r.div == 8'(HALF - 1));
    rdy_w     = s_r.rdy_s[1];
    dn_w      = s_r.dn_s[1];
    er_w      = s_r.er_s[1];
    wr_ctrl_w = avs_write_i && (avs_address_i == `PRH_REG_CTRL);
    wr_data_w = avs_write_i && (avs_address_i == `PRH_REG_DATA);
    start_w   = wr_ctrl_w && avs_writedata_i[`PRH_CTRL_START];
    abort_w   = wr_ctrl_w && avs_writedata_i[`PRH_CTRL_ABORT];
    // a data word is only taken at the drive point; outside a stream
    // it is dropped at once so the bus never hangs
    accept_w  = (s_r.st != PRH_H_STREAM) ||
                (fall_w && !er_w && (s_r.cnt != s_r.len));
  end

  always_comb begin
    s_nxt       = s_r;
    // ready, done and error are asynchronous: two flops first
    s_nxt.rdy_s = {s_r.rdy_s[0], link.reconfig_ready};
    s_nxt.dn_s  = {s_r.dn_s[0], link.reconfig_done};
    s_nxt.er_s  = {s_r.er_s[0], link.reconfig_error};
    // divider never stops, whatever the session state
    s_nxt.div   = rise_w ? 8'h00 : s_r.div + 8'h01;
    if (rise_w) begin
      s_nxt.lclk = 1'b1;
    end else if (fall_w) begin
      s_nxt.lclk = 1'b0;
    end
    s_nxt.rd_pend = avs_read_i && !s_r.rd_pend;
    if (avs_read_i && !s_r.rd_pend) begin
      unique case (avs_address_i)
        `PRH_REG_CTRL: s_nxt.rdata = {26'h0, s_r.width, 4'h0};
        `PRH_REG_LEN:  s_nxt.rdata = s_r.len;
        `PRH_REG_DATA: s_nxt.rdata = s_r.cnt;
        `PRH_REG_STAT: s_nxt.rdata = {21'h0, s_r.st, 3'h0,
                                      s_r.underrun, s_r.err_seen,
                                      s_r.done_seen, rdy_w,
                                      (s_r.st != PRH_H_IDLE)};
        default:       s_nxt.rdata = 32'h0000_0000;
      endcase
    end
    if (avs_write_i && avs_address_i == `PRH_REG_LEN &&
        s_r.st == PRH_H_IDLE) begin
      s_nxt.len = avs_writedata_i;
    end
    unique case (s_r.st)
      PRH_H_IDLE: begin
        s_nxt.data = 32'h0000_0000;
        s_nxt.req  = 1'b0;
        if (start_w) begin
          s_nxt.width     = prh_width_t'(avs_writedata_i[
                              `PRH_CTRL_WIDTH_LSB +: 2]);
          s_nxt.cnt       = 32'h0000_0000;
          s_nxt.done_seen = 1'b0;
          s_nxt.err_seen  = 1'b0;
          s_nxt.underrun  = 1'b0;
          s_nxt.req       = 1'b1;
          s_nxt.st        = PRH_H_REQ;
        end
      end
      PRH_H_REQ: begin
        s_nxt.data = 32'h0000_0000;
        if (abort_w) begin
          // early withdrawal still honours the gap before a new request
          s_nxt.req = 1'b0;
          s_nxt.gap = 4'h0;
          s_nxt.st  = PRH_H_GAP;
        end else if (rdy_w) begin
          s_nxt.st = PRH_H_STREAM;
        end
      end
      PRH_H_STREAM: begin
        if (er_w) begin
          s_nxt.err_seen = 1'b1;
          s_nxt.data     = 32'h0000_0000;
          s_nxt.st       = PRH_H_ERRWAIT;
        end else if (abort_w && s_r.cnt == 32'h0000_0000) begin
          s_nxt.req = 1'b0;
          s_nxt.st  = PRH_H_RELEASE;
        end else if (fall_w) begin
          if (s_r.cnt == s_r.len) begin
            s_nxt.data = 32'h0000_0000;
            s_nxt.st   = PRH_H_FLUSH;
          end else if (wr_data_w) begin
            s_nxt.data = prh_mask(s_r.width, avs_writedata_i);
            s_nxt.cnt  = s_r.cnt + 32'h0000_0001;
          end else if (s_r.cnt != 32'h0000_0000) begin
            // software fell behind the link: the word repeats; before
            // the first word the bus only carries idle fill
            s_nxt.underrun = 1'b1;
          end
        end
      end
      PRH_H_FLUSH: begin
        s_nxt.data = 32'h0000_0000;
        if (er_w) begin
          s_nxt.err_seen = 1'b1;
          s_nxt.st       = PRH_H_ERRWAIT;
        end else if (dn_w) begin
          s_nxt.done_seen = 1'b1;
          s_nxt.req       = 1'b0;
          s_nxt.st        = PRH_H_RELEASE;
        end
      end
      PRH_H_ERRWAIT: begin
        s_nxt.data = 32'h0000_0000;
        if (!rdy_w) begin
          s_nxt.req = 1'b0;
          s_nxt.st  = PRH_H_RELEASE;
        end
      end
      PRH_H_RELEASE: begin
        if (!dn_w && !er_w) begin
          s_nxt.gap = 4'h0;
          s_nxt.st  = PRH_H_GAP;
        end
      end
      PRH_H_GAP: begin
        if (rise_w) begin
          if (s_r.gap == 4'(GAP - 1)) begin
            s_nxt.st = PRH_H_IDLE;
          end else begin
            s_nxt.gap = s_r.gap + 4'h1;
          end
        end
      end
      default: begin
        s_nxt.st = PRH_H_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.reconfig_request = s_r.req;
  assign link.bitstream_clock  = s_r.lclk;
  assign link.bitstream_data   = s_r.data;
  assign link.source_select    = FROM_CORE;
  assign avs_readdata_o        = s_r.rdata;
  assign avs_waitrequest_o     = (avs_read_i && !s_r.rd_pend) ||
                                 (wr_data_w && !accept_w);
endmodule : prh_host

// [tb/prh_monitor.sv]
// link checker: handshake order, clock and request spacing
module prh_monitor #(
  parameter int DIV = 8,
  parameter int GAP = 10
) (
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        reconfig_request,
  input  wire logic        reconfig_ready,
  input  wire logic        reconfig_done,
  input  wire logic        reconfig_error,
  input  wire logic        checksum_error,
  input  wire logic        bitstream_clock,
  input  wire logic [31:0] bitstream_data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!arst_n_i);
  logic [7:0] run_r;
  logic [7:0] gap_r;
  logic       prev_r;
  logic       seen_r;
  // gap counts sampled link rises while request is low, saturating
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      run_r  <= 8'h00;
      gap_r  <= 8'hFF;
      prev_r <= 1'b0;
      seen_r <= 1'b0;
    end else begin
      prev_r <= bitstream_clock;
      seen_r <= seen_r | bitstream_clock;
      run_r  <= (bitstream_clock != prev_r) ? 8'h00 : run_r + 8'h01;
      if (reconfig_request) begin
        gap_r <= 8'h00;
      end else if (bitstream_clock && !prev_r && gap_r != 8'hFF) begin
        gap_r <= gap_r + 8'h01;
      end
    end
  end
  rdy_needs_req_a: assert property (
    $rose(reconfig_ready) |-> reconfig_request)
    else $error("ready rose without request");
  rdy_withdraw_a: assert property (
    $fell(reconfig_request) |-> ##[1:4] !reconfig_ready)
    else $error("ready stayed high after withdrawal");
  done_rdy_a: assert property (
    $rose(reconfig_done) |-> !reconfig_ready)
    else $error("done rose while ready high");
  done_hold_a: assert property (
    reconfig_done && reconfig_request |=> reconfig_done)
    else $error("done fell while request high");
  done_drop_a: assert property (
    $fell(reconfig_request) && reconfig_done |-> ##[1:4] !reconfig_done)
    else $error("done not lowered after request fell");
  err_rdy_a: assert property (
    $rose(reconfig_error) |=> !reconfig_ready)
    else $error("ready high after error");
  cks_first_a: assert property (
    $rose(checksum_error) |=> $rose(reconfig_error))
    else $error("error did not follow checksum error");
  err_clear_a: assert property (
    reconfig_error && !reconfig_request && !reconfig_ready
      |-> ##[1:8] !reconfig_error)
    else $error("error not cleared");
  cks_clear_a: assert property (
    checksum_error && !reconfig_request && !reconfig_ready
      |-> ##[1:8] !checksum_error)
    else $error("checksum error not cleared");
  data_idle_a: assert property (
    $rose(reconfig_request) |-> bitstream_data == 32'h0)
    else $error("data not zero at request");
  clk_run_a: assert property (
    seen_r |-> run_r < DIV / 2)
    else $error("link clock stalled");
  req_gap_a: assert property (
    $rose(reconfig_request) |-> gap_r >= GAP)
    else $error("request raised too soon");
endmodule : prh_monitor

// [tb/partial_reconfig_handshake_test.sv]
// self-checking bench: host and control block joined by the link
`include "prh_defines.svh"
module partial_reconfig_handshake_test import prh_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk_i = 1'b0;
  logic        arst_n_i   = 1'b0;
  logic [3:0]  adr        = 4'h0;
  logic        rd         = 1'b0;
  logic        wr         = 1'b0;
  logic [31:0] wdat       = 32'h0;
  logic [31:0] rdat;
  logic        wreq;
  prh_width_t  width      = PRH_W32;
  logic [31:0] len        = 32'h1;
  logic        fault      = 1'b0;
  logic        mism       = 1'b0;
  logic [31:0] word;
  logic        wvalid;
  logic [31:0] lfsr       = 32'h105E;
  logic [31:0] q;
  logic        ign        = 1'b0;
  logic        rdy_prev   = 1'b0;
  logic        cks_prev   = 1'b0;
  int          rdy_rises  = 0;
  int          cks_rises  = 0;
  logic [31:0] expq[$];
  int          bad_count  = 0;
  int          samples_checked = 0;
  int          cyc        = 0;
  prh_if link();
  always #20 core_clk_i = ~core_clk_i;
  prh_host #(.DIV(8), .GAP(10)) i_prh_host (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(link.host),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wreq));
  // pin mode tied low: the host is core logic, so sessions are accepted
  prh_device i_prh_device (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .link(link.device),
    .pin_mode_i(1'b0), .width_i(width), .length_i(len),
    .xfer_fault_i(fault), .frame_mismatch_i(mism),
    .word_o(word), .word_valid_o(wvalid));
  prh_monitor #(.DIV(8), .GAP(10)) i_prh_monitor (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i),
    .reconfig_request(link.reconfig_request),
    .reconfig_ready(link.reconfig_ready),
    .reconfig_done(link.reconfig_done),
    .reconfig_error(link.reconfig_error),
    .checksum_error(link.checksum_error),
    .bitstream_clock(link.bitstream_clock),
    .bitstream_data(link.bitstream_data));
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic conclude();
    $display("checked %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  function automatic logic [31:0] nxt(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nxt
  // one bus cycle; held until waitrequest is sampled low, however long
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d);
    @(posedge core_clk_i);
    adr  <= a;
    wr   <= w;
    rd   <= !w;
    wdat <= d;
    do begin
      @(posedge core_clk_i);
    end while (wreq !== 1'b0);
    q = rdat;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : bus
  // polls status; only the run's own timeout ends a wait
  task automatic wait_st(input logic [2:0] s);
    do begin
      bus(1'b0, 4'hC, 32'h0);
    end while (q[10:8] !== s);
  endtask : wait_st
  // kind 0 clean, 1 transfer fault, 2 checksum mismatch,
  // 3 withdrawal after ready, 4 withdrawal before ready
  task automatic sess(input prh_width_t w, input int n, input int kind);
    logic [31:0] m;
    int          r0;
    int          c0;
    m = (w == PRH_W8) ? 32'hFF : (w == PRH_W16) ? 32'hFFFF : 32'hFFFF_FFFF;
    r0 = rdy_rises;
    c0 = cks_rises;
    @(posedge core_clk_i);
    width <= w;
    len   <= n;
    ign = (kind != 0);
    bus(1'b1, 4'h4, n);
    bus(1'b1, 4'h0, {26'h0, w, 4'h1});
    if (kind == 4) begin
      bus(1'b1, 4'h0, {26'h0, w, 4'h2});
    end else begin
      wait_st(3'h3);
      chk("stream state", 32'h3, {29'h0, q[10:8]});
      // faults only once streaming: earlier, the stream state is too
      // short for the status poll to catch
      fault <= (kind == 1);
      mism  <= (kind == 2);
      if (kind == 3) bus(1'b1, 4'h0, {26'h0, w, 4'h2});
      else for (int i = 0; i < n; i++) begin
        lfsr = nxt(lfsr);
        if (kind == 0) expq.push_back((lfsr | 32'h1) & m);
        bus(1'b1, 4'h8, lfsr | 32'h1);
      end
    end
    if (kind == 0) begin
      bus(1'b0, 4'h8, 32'h0);
      chk("words sent", n, q);
    end
    wait_st(3'h0);
    fault <= 1'b0;
    mism  <= 1'b0;
    chk("done seen", {31'h0, kind == 0}, {31'h0, q[2]});
    chk("error seen", 32'(kind == 1 || kind == 2), 32'(q[3]));
    if (kind == 0) chk("underrun", 32'h0, 32'(q[4]));
    chk("ready rises", 32'(kind != 4), rdy_rises - r0);
    chk("cksum rises", 32'(kind == 2), cks_rises - c0);
    chk("words left", 32'h0, expq.size());
    bus(1'b0, 4'h0, 32'h0);
    chk("width kept", 32'(w) << `PRH_CTRL_WIDTH_LSB, q);
    $display("session kind %0d width %0d finished", kind, w);
  endtask : sess
  always @(posedge core_clk_i) begin
    cyc      <= cyc + 1;
    rdy_prev <= link.reconfig_ready;
    cks_prev <= link.checksum_error;
    if (link.reconfig_ready === 1'b1 && rdy_prev !== 1'b1)
      rdy_rises <= rdy_rises + 1;
    if (link.checksum_error === 1'b1 && cks_prev !== 1'b1)
      cks_rises <= cks_rises + 1;
    if (wvalid === 1'b1 && !ign) begin
      if (expq.size() == 0) chk("extra word", 32'h0, word);
      else chk("word", expq.pop_front(), word);
    end
    if (cyc == 20000) begin
      bad_count++;
      conclude();
    end
  end
  initial begin
    repeat (16) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    bus(1'b0, 4'h4, 32'h0);
    chk("length reset", `PRH_LEN_RESET, q);
    bus(1'b1, 4'h4, 32'h5);
    bus(1'b1, 4'h2, 32'hFF);
    bus(1'b0, 4'h4, 32'h0);
    chk("length kept", 32'h5, q);
    $display("register test finished");
    for (int w = 0; w < 3; w++) sess(prh_width_t'(w), w + 2, 0);
    for (int k = 1; k < 5; k++) sess(PRH_W32, 3, k);
    conclude();
  end
endmodule : partial_reconfig_handshake_test
